// >>> logic/pdc_regs.v
// register bank for prescalers, feedback divider and charge pump current
//
// Contract
// - prescaler two ratio bits 4:3, reset divide three
// - prescaler two regulator and main enable reset on
// - prescaler two clear bit pulses live, self clears
// - prescaler three ratio bits 3:2, reset divide two
// - prescaler three enable reset on, live clear
// - feedback ratio direct, reset 0x0A
// - feedback ratio zero disables the divider
// - feedback control bit 0 pulses live clear
// - pump current equals code plus one times 50uA
// - pump codes above 0x33 saturate at maximum
// - prescaler one mirrors prescaler two layout
`timescale 1ns/10ps
`include "pdc_defines.vh"

module pdc_regs (
    input wire i_clk, // system clock, 20 MHz
    input wire i_rst, // synchronous reset, active high
    input wire i_wr_en, // one-cycle register write strobe
    input wire i_rd_en, // one-cycle register read strobe
    input wire [`PDC_ADDR_W-1:0] i_addr, // register address
    input wire [7:0] i_wr_data, // write data
    input wire i_xfer, // transfer strobe, buffered to active
    output reg [7:0] o_rd_data, // read data
    output reg o_rd_valid, // read data valid pulse
    output reg [1:0] o_prescaler_one_ratio, // prescaler one ratio code
    output reg o_prescaler_one_regulator_on, // prescaler one regulator
    output reg o_prescaler_one_on, // prescaler one enable
    output reg o_prescaler_one_clear, // prescaler one reset pulse
    output reg [1:0] o_prescaler_two_ratio, // prescaler two ratio code
    output reg o_prescaler_two_regulator_on, // prescaler two regulator
    output reg o_prescaler_two_on, // prescaler two enable
    output reg o_prescaler_two_clear, // prescaler two reset pulse
    output reg [1:0] o_prescaler_three_ratio, // prescaler three ratio
    output reg o_prescaler_three_on, // prescaler three enable
    output reg o_prescaler_three_clear, // prescaler three reset pulse
    output reg [7:0] o_feedback_ratio, // feedback divide ratio
    output reg o_feedback_on, // feedback divider enable
    output reg o_feedback_clear, // feedback divider reset pulse
    output reg [5:0] o_pump_current_code, // saturated pump code
    output reg [11:0] o_pump_current_ua // pump current in microamps
);

    // buffered (software-visible) copies
    reg [7:0] pre_one_ff;
    reg [7:0] pre_two_ff;
    reg [7:0] pre_three_ff;
    reg [7:0] fb_ratio_ff;
    reg [7:0] pump_ff;

    // register reset images, sliced for the active copies
    localparam [7:0] RST_ONE = `PDC_RST_PRE_ONE;
    localparam [7:0] RST_TWO = `PDC_RST_PRE_TWO;
    localparam [7:0] RST_THREE = `PDC_RST_PRE_THREE;
    localparam [7:0] RST_FB = `PDC_RST_FB_RATIO;
    localparam [7:0] RST_PUMP = `PDC_RST_PUMP;

    wire wr_pre_one = i_wr_en && (i_addr == `PDC_OFS_PRE_ONE);
    wire wr_pre_two = i_wr_en && (i_addr == `PDC_OFS_PRE_TWO);
    wire wr_pre_three = i_wr_en && (i_addr == `PDC_OFS_PRE_THREE);
    wire wr_fb_ratio = i_wr_en && (i_addr == `PDC_OFS_FB_RATIO);
    wire wr_fb_ctrl = i_wr_en && (i_addr == `PDC_OFS_FB_CTRL);
    wire wr_pump = i_wr_en && (i_addr == `PDC_OFS_PUMP);

    // saturation of the pump code
    wire [5:0] pump_code = pump_ff[`PDC_PUMP_HI:0];
    wire [5:0] pump_sat = (pump_code > `PDC_PUMP_MAX) ?
        `PDC_PUMP_MAX : pump_code;
    wire [11:0] pump_ua = ({6'h00, pump_sat} + 12'h0001) *
        `PDC_PUMP_STEP_UA;

    reg [7:0] nxt_rd_data;

    always @* begin
        case (i_addr)
            `PDC_OFS_PRE_ONE: nxt_rd_data = pre_one_ff & `PDC_PRE_WRITE_MASK;
            `PDC_OFS_PRE_TWO: nxt_rd_data = pre_two_ff & `PDC_PRE_WRITE_MASK;
            `PDC_OFS_PRE_THREE:
                nxt_rd_data = pre_three_ff & `PDC_PRE3_WRITE_MASK;
            `PDC_OFS_FB_RATIO: nxt_rd_data = fb_ratio_ff;
            `PDC_OFS_PUMP: nxt_rd_data = pump_ff & `PDC_PUMP_WRITE_MASK;
            default: nxt_rd_data = 8'h00;
        endcase
    end

    // buffered registers; reserved and clear bits are not stored
    always @(posedge i_clk) begin
        if (i_rst)
            pre_one_ff <= RST_ONE;
        else if (wr_pre_one)
            pre_one_ff <= i_wr_data & `PDC_PRE_WRITE_MASK;
    end

    always @(posedge i_clk) begin
        if (i_rst)
            pre_two_ff <= RST_TWO;
        else if (wr_pre_two)
            pre_two_ff <= i_wr_data & `PDC_PRE_WRITE_MASK;
    end

    always @(posedge i_clk) begin
        if (i_rst)
            pre_three_ff <= RST_THREE;
        else if (wr_pre_three)
            pre_three_ff <= i_wr_data & `PDC_PRE3_WRITE_MASK;
    end

    always @(posedge i_clk) begin
        if (i_rst)
            fb_ratio_ff <= RST_FB;
        else if (wr_fb_ratio)
            fb_ratio_ff <= i_wr_data;
    end

    always @(posedge i_clk) begin
        if (i_rst)
            pump_ff <= RST_PUMP;
        else if (wr_pump)
            pump_ff <= i_wr_data & `PDC_PUMP_WRITE_MASK;
    end

    // live clear pulses, one cycle per write with bit 0 set
    always @(posedge i_clk) begin
        if (i_rst)
            o_prescaler_one_clear <= 1'b0;
        else
            o_prescaler_one_clear <=
                wr_pre_one && i_wr_data[`PDC_PRE_CLEAR];
    end

    always @(posedge i_clk) begin
        if (i_rst)
            o_prescaler_two_clear <= 1'b0;
        else
            o_prescaler_two_clear <=
                wr_pre_two && i_wr_data[`PDC_PRE_CLEAR];
    end

    always @(posedge i_clk) begin
        if (i_rst)
            o_prescaler_three_clear <= 1'b0;
        else
            o_prescaler_three_clear <=
                wr_pre_three && i_wr_data[`PDC_PRE3_CLEAR];
    end

    always @(posedge i_clk) begin
        if (i_rst)
            o_feedback_clear <= 1'b0;
        else
            o_feedback_clear <=
                wr_fb_ctrl && i_wr_data[`PDC_FB_CLEAR];
    end

    // active copies, loaded only on the transfer strobe; a write in the
    // transfer cycle reaches the buffer only and waits for the next one
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_prescaler_one_ratio <=
                RST_ONE[`PDC_PRE_RATIO_HI:`PDC_PRE_RATIO_LO];
            o_prescaler_one_regulator_on <= RST_ONE[`PDC_PRE_REG_ON];
            o_prescaler_one_on <= RST_ONE[`PDC_PRE_ON];
        end else if (i_xfer) begin
            o_prescaler_one_ratio <=
                pre_one_ff[`PDC_PRE_RATIO_HI:`PDC_PRE_RATIO_LO];
            o_prescaler_one_regulator_on <= pre_one_ff[`PDC_PRE_REG_ON];
            o_prescaler_one_on <= pre_one_ff[`PDC_PRE_ON];
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_prescaler_two_ratio <=
                RST_TWO[`PDC_PRE_RATIO_HI:`PDC_PRE_RATIO_LO];
            o_prescaler_two_regulator_on <= RST_TWO[`PDC_PRE_REG_ON];
            o_prescaler_two_on <= RST_TWO[`PDC_PRE_ON];
        end else if (i_xfer) begin
            o_prescaler_two_ratio <=
                pre_two_ff[`PDC_PRE_RATIO_HI:`PDC_PRE_RATIO_LO];
            o_prescaler_two_regulator_on <= pre_two_ff[`PDC_PRE_REG_ON];
            o_prescaler_two_on <= pre_two_ff[`PDC_PRE_ON];
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_prescaler_three_ratio <=
                RST_THREE[`PDC_PRE3_RATIO_HI:`PDC_PRE3_RATIO_LO];
            o_prescaler_three_on <= RST_THREE[`PDC_PRE3_ON];
        end else if (i_xfer) begin
            o_prescaler_three_ratio <=
                pre_three_ff[`PDC_PRE3_RATIO_HI:`PDC_PRE3_RATIO_LO];
            o_prescaler_three_on <= pre_three_ff[`PDC_PRE3_ON];
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_feedback_ratio <= RST_FB;
            o_feedback_on <= (RST_FB != `PDC_FB_OFF_CODE);
        end else if (i_xfer) begin
            o_feedback_ratio <= fb_ratio_ff;
            o_feedback_on <= (fb_ratio_ff != `PDC_FB_OFF_CODE);
        end
    end

    // reset current is worked out from the reset code, as in operation
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_pump_current_code <= RST_PUMP[`PDC_PUMP_HI:0];
            o_pump_current_ua <= ({6'h00, RST_PUMP[`PDC_PUMP_HI:0]} +
                12'h0001) * `PDC_PUMP_STEP_UA;
        end else if (i_xfer) begin
            o_pump_current_code <= pump_sat;
            o_pump_current_ua <= pump_ua;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst)
            o_rd_valid <= 1'b0;
        else
            o_rd_valid <= i_rd_en;
    end

    // read data holds until the next read strobe
    always @(posedge i_clk) begin
        if (i_rst)
            o_rd_data <= 8'h00;
        else if (i_rd_en)
            o_rd_data <= nxt_rd_data;
    end

endmodule

// >>> logic/pdc_defines.vh
// register offsets, field positions, reset values for the divider config bank
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

`define PDC_ADDR_W 12
`define PDC_OFS_PRE_ONE 12'h0020
`define PDC_OFS_PRE_TWO 12'h0021
`define PDC_OFS_PRE_THREE 12'h0022
`define PDC_OFS_FB_RATIO 12'h0023
`define PDC_OFS_FB_CTRL 12'h0024
`define PDC_OFS_PUMP 12'h0025

`define PDC_RST_PRE_ONE 8'h16
`define PDC_RST_PRE_TWO 8'h16
`define PDC_RST_PRE_THREE 8'h02
`define PDC_RST_FB_RATIO 8'h0a
`define PDC_RST_PUMP 8'h07

// prescaler one and two layout
`define PDC_PRE_RATIO_HI 4
`define PDC_PRE_RATIO_LO 3
`define PDC_PRE_REG_ON 2
`define PDC_PRE_ON 1
`define PDC_PRE_CLEAR 0
// prescaler three layout
`define PDC_PRE3_RATIO_HI 3
`define PDC_PRE3_RATIO_LO 2
`define PDC_PRE3_ON 1
`define PDC_PRE3_CLEAR 0
// feedback divider control
`define PDC_FB_CLEAR 0
`define PDC_FB_OFF_CODE 8'h00
// charge pump
`define PDC_PUMP_HI 5
`define PDC_PUMP_MAX 6'h33
`define PDC_PUMP_STEP_UA 12'h0032
`define PDC_PUMP_WRITE_MASK 8'h3f
`define PDC_PRE_WRITE_MASK 8'h1e
`define PDC_PRE3_WRITE_MASK 8'h0e

`endif

// >>> verification/pdc_regs_properties.sv
// assertions for the divider config register bank
`timescale 1ns/10ps
`include "pdc_defines.vh"
module pdc_regs_check (
    input wire i_clk, // clock
    input wire i_rst, // reset
    input wire i_wr_en, // write strobe
    input wire i_xfer, // transfer strobe
    input wire [`PDC_ADDR_W-1:0] i_addr, // address
    input wire [7:0] i_wr_data, // write data
    input wire [7:0] o_feedback_ratio, // active feedback ratio
    input wire o_prescaler_two_clear, // clear pulse
    input wire o_prescaler_three_clear, // clear pulse
    input wire o_feedback_clear, // clear pulse
    input wire o_feedback_on, // feedback enable
    input wire [1:0] o_prescaler_two_ratio, // ratio code
    input wire [5:0] o_pump_current_code, // pump code
    input wire [11:0] o_pump_current_ua // pump microamps
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire wc = i_wr_en & i_wr_data[0];
    pre2_clr_a: assert property (
        wc && i_addr == `PDC_OFS_PRE_TWO |=> o_prescaler_two_clear
        ##1 (o_prescaler_two_clear ==
        $past(wc && i_addr == `PDC_OFS_PRE_TWO)))
        else $error("pre two clear");
    pre3_clr_a: assert property (
        wc && i_addr == `PDC_OFS_PRE_THREE |=> o_prescaler_three_clear
        ##1 (o_prescaler_three_clear ==
        $past(wc && i_addr == `PDC_OFS_PRE_THREE)))
        else $error("pre three clear");
    fb_clr_a: assert property (
        wc && i_addr == `PDC_OFS_FB_CTRL |=> o_feedback_clear)
        else $error("feedback clear");
    fb_quiet_a: assert property (
        !(wc && i_addr == `PDC_OFS_FB_CTRL) |=> !o_feedback_clear)
        else $error("spurious feedback clear");
    fb_off_a: assert property (
        o_feedback_on == (o_feedback_ratio != `PDC_FB_OFF_CODE))
        else $error("feedback enable");
    pump_ua_a: assert property (o_pump_current_ua ==
        ({6'h00, o_pump_current_code} + 12'h001) * `PDC_PUMP_STEP_UA)
        else $error("pump current");
    pump_sat_a: assert property (
        o_pump_current_code <= `PDC_PUMP_MAX) else $error("pump sat");
    xfer_hold_a: assert property (
        !$past(i_xfer) && !$past(i_rst) |-> $stable({o_feedback_ratio,
        o_pump_current_code, o_prescaler_two_ratio}))
        else $error("active field moved");
    cover property (i_xfer);
    cover property (o_feedback_clear);
    cover property (o_pump_current_code == `PDC_PUMP_MAX);
endmodule
bind pdc_regs pdc_regs_check u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_wr_en(i_wr_en), .i_xfer(i_xfer), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .o_feedback_ratio(o_feedback_ratio),
    .o_prescaler_two_clear(o_prescaler_two_clear),
    .o_prescaler_three_clear(o_prescaler_three_clear),
    .o_feedback_clear(o_feedback_clear), .o_feedback_on(o_feedback_on),
    .o_prescaler_two_ratio(o_prescaler_two_ratio),
    .o_pump_current_code(o_pump_current_code),
    .o_pump_current_ua(o_pump_current_ua));

// >>> verification/pdc_regs_bench.sv
// self-checking bench for the divider config register bank
`timescale 1ns/10ps
module pdc_regs_bench;
    reg i_clk = 0, i_rst = 1, i_wr_en = 0, i_rd_en = 0, i_xfer = 0;
    reg [11:0] i_addr = 0;
    reg [7:0] i_wr_data = 0;
    wire [7:0] rdat, fb;
    wire rv, p1g, p1e, p1c, p2g, p2e, p2c, p3e, p3c, fbe, fbc;
    wire [1:0] p1, p2, p3;
    wire [5:0] pc;
    wire [11:0] ua;
    integer error_cnt = 0, checked = 0, i;
    pdc_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_xfer(i_xfer), .o_rd_data(rdat), .o_rd_valid(rv),
        .o_prescaler_one_ratio(p1), .o_prescaler_one_regulator_on(p1g),
        .o_prescaler_one_on(p1e), .o_prescaler_one_clear(p1c),
        .o_prescaler_two_ratio(p2), .o_prescaler_two_regulator_on(p2g),
        .o_prescaler_two_on(p2e), .o_prescaler_two_clear(p2c),
        .o_prescaler_three_ratio(p3), .o_prescaler_three_on(p3e),
        .o_prescaler_three_clear(p3c), .o_feedback_ratio(fb),
        .o_feedback_on(fbe), .o_feedback_clear(fbc),
        .o_pump_current_code(pc), .o_pump_current_ua(ua));
    initial forever #25 i_clk = ~i_clk;
    task chk(input [11:0] s, input [11:0] e);
        begin
            checked = checked + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask
    task step;
        begin
            @(posedge i_clk);
            #1;
        end
    endtask
    // caller steps before the next write, so the strobe drops for a cycle
    task wr(input [11:0] a, input [7:0] d);
        begin
            i_wr_en = 1;
            i_addr = a;
            i_wr_data = d;
            step;
            i_wr_en = 0;
        end
    endtask
    task rd(input [11:0] a, input [7:0] e);
        begin
            i_rd_en = 1;
            i_addr = a;
            step;
            i_rd_en = 0;
            chk(rv, 12'h001);
            chk(rdat, e);
            step;
        end
    endtask
    task upd;
        begin
            i_xfer = 1;
            step;
            i_xfer = 0;
        end
    endtask
    task t_reset;
        begin
            rd(12'h020, 8'h16);
            rd(12'h021, 8'h16);
            rd(12'h022, 8'h02);
            rd(12'h023, 8'h0a);
            rd(12'h025, 8'h07);
            chk({p2, p2g, p2e, p1, p1g, p1e}, 12'h0bb);
            chk({p3, p3e, fbe, fb}, 12'h30a);
            chk(ua, 12'h190);
            chk(pc, 12'h007);
            $display("reset test done");
        end
    endtask
    task t_clear;
        begin
            wr(12'h021, 8'h19);
            chk({p2c, p2}, 12'h006);
            step;
            chk(p2c, 12'h000);
            rd(12'h021, 8'h18);
            upd;
            chk({p2, p2g, p2e}, 12'h00c);
            wr(12'h022, 8'h0d);
            chk(p3c, 12'h001);
            step;
            rd(12'h022, 8'h0c);
            upd;
            chk({p3, p3e, p3c}, 12'h00c);
            wr(12'h020, 8'h09);
            chk(p1c, 12'h001);
            step;
            wr(12'h024, 8'h01);
            chk(fbc, 12'h001);
            step;
            rd(12'h024, 8'h00);
            upd;
            chk({p1, p1g, p1e}, 12'h004);
            $display("clear test done");
        end
    endtask
    task t_div;
        begin
            wr(12'h023, 8'h00);
            upd;
            chk({fbe, fb}, 12'h000);
            wr(12'h023, 8'hff);
            upd;
            chk({fbe, fb}, 12'h1ff);
            for (i = 50; i < 54; i = i + 1) begin
                wr(12'h025, i[7:0]);
                upd;
                chk(pc, (i > 51) ? 51 : i);
                chk(ua, ((i > 51) ? 52 : i + 1) * 50);
            end
            $display("divider test done");
        end
    endtask
    task t_rerst;
        begin
            i_rst = 1;
            step;
            i_rst = 0;
            chk({fbe, fb}, 12'h10a);
            chk({p2, p2g, p2e}, 12'h00b);
            chk(pc, 12'h007);
            chk(ua, 12'h190);
            $display("mid-run reset test done");
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        #40000;
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge i_clk);
        #1;
        i_rst = 0;
        t_reset;
        t_clear;
        t_div;
        t_rerst;
        report_and_stop;
    end
endmodule
